// [mbbhp_pkg.sv]
// Purpose: shared constants for the muxed byte bus host port
// Assumes: one core clock, strobes arrive asynchronously from the host
// Notes:   no software-visible registers
package mbbhp_pkg;
	localparam int DATA_W            = 8;
	localparam int SYNC_STAGES       = 3;
	localparam logic       SYNC_RESET_VAL  = 1'b0;
	localparam logic       STYLE_RESET_VAL = 1'b0;
	localparam logic [7:0] ADDR_RESET_VAL  = 8'h00;
	localparam logic [7:0] DATA_RESET_VAL  = 8'h00;

	typedef enum logic [1:0] {
		MBBHP_IDLE,
		MBBHP_ADDR,
		MBBHP_READ
	} mbbhp_state_t;
endpackage

// [mbbhp_sync.sv]
// Purpose: three-flop synchroniser with agreement filter for one pin
// Assumes: i_pin is asynchronous to i_core_clk
// Notes:   output changes only when stages two and three agree
`timescale 1ns/10ps
module mbbhp_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic i_core_clk,
	input  wire logic i_rst,
	input  wire logic i_pin,
	output logic      o_level
);
	// ==========================================================
	// sampling chain
	logic [2:0] chain_reg;
	logic [2:0] chain_next;
	logic       level_reg;
	logic       level_next;

	always_comb begin
		chain_next = {chain_reg[1:0], i_pin};
		level_next = level_reg;
		// stage one is never looked at directly, only stages two and three
		if (chain_reg[1] == chain_reg[2]) begin
			level_next = chain_reg[2];
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			chain_reg <= {3{RESET_VAL}};
			level_reg <= RESET_VAL;
		end else begin
			chain_reg <= chain_next;
			level_reg <= level_next;
		end
	end

	assign o_level = level_reg;
endmodule

// [mbbhp_port.sv]
// Purpose: multiplexed byte-wide host port with two strobe styles
// Assumes: host strobes, select and bus are asynchronous; storage lies outside
// Notes:   address and write data are taken from a clocked copy of the bus
`timescale 1ns/10ps
module mbbhp_port (
	input  wire logic       i_core_clk,
	input  wire logic       i_rst,
	input  wire logic       i_bus_style_select,
	input  wire logic       i_address_strobe,
	input  wire logic       i_data_or_read_strobe,
	input  wire logic       i_read_write,
	input  wire logic       i_chip_select_n,
	input  wire logic       i_power_fail_threshold,
	input  wire logic [7:0] i_muxed_addr_data_bus,
	output logic      [7:0] o_muxed_addr_data_bus,
	output logic            o_muxed_addr_data_bus_oe,
	input  wire logic [7:0] i_read_data,
	output logic      [7:0] o_addr,
	output logic            o_addr_valid,
	output logic            o_read_req,
	output logic      [7:0] o_write_data,
	output logic            o_write_req,
	output logic            o_strobe_style
);
	// ==========================================================
	// synchronisers
	logic as_s;
	logic ds_s;
	logic rw_s;
	logic csn_s;
	logic pf_s;
	logic sty_s;
	logic [7:0] bus_s;

	mbbhp_sync #(.RESET_VAL(1'b0)) u_as (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_pin(i_address_strobe), .o_level(as_s));
	mbbhp_sync #(.RESET_VAL(1'b1)) u_ds (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_pin(i_data_or_read_strobe), .o_level(ds_s));
	mbbhp_sync #(.RESET_VAL(1'b1)) u_rw (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_pin(i_read_write), .o_level(rw_s));
	mbbhp_sync #(.RESET_VAL(1'b1)) u_cs (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_pin(i_chip_select_n), .o_level(csn_s));
	mbbhp_sync #(.RESET_VAL(1'b0)) u_pf (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_pin(i_power_fail_threshold), .o_level(pf_s));
	mbbhp_sync #(.RESET_VAL(1'b0)) u_sty (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_pin(i_bus_style_select), .o_level(sty_s));

	genvar gi;
	generate
		for (gi = 0; gi < mbbhp_pkg::DATA_W; gi++) begin : g_bus
			mbbhp_sync #(.RESET_VAL(1'b0)) u_bit (.i_core_clk(i_core_clk), .i_rst(i_rst),
				.i_pin(i_muxed_addr_data_bus[gi]), .o_level(bus_s[gi]));
		end
	endgenerate

	// ==========================================================
	// edge history
	logic as_d_reg, as_d_next;
	logic ds_d_reg, ds_d_next;
	logic rw_d_reg, rw_d_next;

	always_comb begin
		as_d_next = as_s;
		ds_d_next = ds_s;
		rw_d_next = rw_s;
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			as_d_reg <= mbbhp_pkg::SYNC_RESET_VAL;
			ds_d_reg <= 1'b1;
			rw_d_reg <= 1'b1;
		end else begin
			as_d_reg <= as_d_next;
			ds_d_reg <= ds_d_next;
			rw_d_reg <= rw_d_next;
		end
	end

	logic as_fall, as_rise, ds_fall, ds_rise, rw_rise;
	logic sel;
	logic strobe_mode;
	logic read_level;

	assign as_fall     = as_d_reg & ~as_s;
	assign as_rise     = ~as_d_reg & as_s;
	assign ds_fall     = ds_d_reg & ~ds_s;
	assign ds_rise     = ~ds_d_reg & ds_s;
	assign rw_rise     = ~rw_d_reg & rw_s;
	assign strobe_mode = sty_s;
	// power fail acts as if select were released
	assign sel         = ~csn_s & ~pf_s;
	// strobe style: both high; ram style: read low with write high
	assign read_level  = strobe_mode ? (ds_s & rw_s) : (~ds_s & rw_s);

	// ==========================================================
	// port state
	mbbhp_pkg::mbbhp_state_t state_reg, state_next;
	logic [7:0] addr_reg, addr_next;
	logic       addr_valid_reg, addr_valid_next;
	logic [7:0] wdata_reg, wdata_next;
	logic       wreq_reg, wreq_next;
	logic       rreq_reg, rreq_next;
	logic [7:0] dout_reg, dout_next;
	logic       oe_reg, oe_next;
	logic       style_reg, style_next;

	always_comb begin
		state_next      = state_reg;
		addr_next       = addr_reg;
		addr_valid_next = addr_valid_reg;
		wdata_next      = wdata_reg;
		wreq_next       = 1'b0;
		rreq_next       = 1'b0;
		dout_next       = dout_reg;
		oe_next         = oe_reg;
		style_next      = strobe_mode;
		if (as_rise) begin
			addr_valid_next = 1'b0;
			oe_next         = 1'b0;
			state_next      = mbbhp_pkg::MBBHP_IDLE;
		end
		case (state_reg)
			mbbhp_pkg::MBBHP_IDLE: begin
				if (as_fall) begin
					// address is latched even with select inactive
					addr_next       = bus_s;
					addr_valid_next = 1'b1;
					state_next      = mbbhp_pkg::MBBHP_ADDR;
				end
			end
			mbbhp_pkg::MBBHP_ADDR: begin
				// one access per address phase; a new strobe is needed after it
				if (strobe_mode && ds_fall && !rw_s) begin
					if (sel) begin
						wdata_next = bus_s;
						wreq_next  = 1'b1;
					end
					addr_valid_next = 1'b0;
					state_next      = mbbhp_pkg::MBBHP_IDLE;
				end else if (!strobe_mode && rw_rise) begin
					if (sel) begin
						wdata_next = bus_s;
						wreq_next  = 1'b1;
					end
					addr_valid_next = 1'b0;
					state_next      = mbbhp_pkg::MBBHP_IDLE;
				end else if (read_level) begin
					if (sel) begin
						rreq_next = 1'b1;
						oe_next   = 1'b1;
					end
					state_next = mbbhp_pkg::MBBHP_READ;
				end
			end
			mbbhp_pkg::MBBHP_READ: begin
				dout_next = i_read_data;
				if ((strobe_mode && ds_fall) || (!strobe_mode && ds_rise) || !sel) begin
					oe_next         = 1'b0;
					addr_valid_next = 1'b0;
					state_next      = mbbhp_pkg::MBBHP_IDLE;
				end
			end
			default: begin
				state_next = mbbhp_pkg::MBBHP_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg      <= mbbhp_pkg::MBBHP_IDLE;
			addr_reg       <= mbbhp_pkg::ADDR_RESET_VAL;
			addr_valid_reg <= 1'b0;
			wdata_reg      <= mbbhp_pkg::DATA_RESET_VAL;
			wreq_reg       <= 1'b0;
			rreq_reg       <= 1'b0;
			dout_reg       <= mbbhp_pkg::DATA_RESET_VAL;
			oe_reg         <= 1'b0;
			style_reg      <= mbbhp_pkg::STYLE_RESET_VAL;
		end else begin
			state_reg      <= state_next;
			addr_reg       <= addr_next;
			addr_valid_reg <= addr_valid_next;
			wdata_reg      <= wdata_next;
			wreq_reg       <= wreq_next;
			rreq_reg       <= rreq_next;
			dout_reg       <= dout_next;
			oe_reg         <= oe_next;
			style_reg      <= style_next;
		end
	end

	// ==========================================================
	// outputs
	assign o_addr                   = addr_reg;
	assign o_addr_valid             = addr_valid_reg;
	assign o_read_req               = rreq_reg;
	assign o_write_data             = wdata_reg;
	assign o_write_req              = wreq_reg;
	assign o_muxed_addr_data_bus    = dout_reg;
	assign o_muxed_addr_data_bus_oe = oe_reg;
	assign o_strobe_style           = style_reg;
endmodule

// [mbbhp_port_chk.sv]
// Purpose: port assertions for the muxed byte bus host port
// Assumes: host holds every pin level for at least 8 clocks
// Notes:   windows allow for the 3-flop synchronisers
`timescale 1ns/10ps
module mbbhp_port_chk (
	input wire logic       i_core_clk,
	input wire logic       i_rst,
	input wire logic       i_bus_style_select,
	input wire logic       i_address_strobe,
	input wire logic       i_data_or_read_strobe,
	input wire logic       i_read_write,
	input wire logic       i_chip_select_n,
	input wire logic       i_power_fail_threshold,
	input wire logic [7:0] i_read_data,
	input wire logic [7:0] o_muxed_addr_data_bus,
	input wire logic       o_muxed_addr_data_bus_oe,
	input wire logic       o_addr_valid,
	input wire logic       o_read_req,
	input wire logic       o_write_req,
	input wire logic       o_strobe_style
);
	// ==========
	// assertions
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	AST_STYLE: assert property (i_bus_style_select[*8] |-> o_strobe_style)
		else $error("style not followed");
	AST_WR_SEL: assert property (o_write_req |->
		!$past(i_chip_select_n, 5) && !$past(i_power_fail_threshold, 5))
		else $error("write while not selected");
	AST_RD_SEL: assert property (o_read_req |->
		!$past(i_chip_select_n, 5) && !$past(i_power_fail_threshold, 5))
		else $error("read while not selected");
	AST_WR_RAM: assert property (o_write_req && !o_strobe_style |-> $past(i_read_write))
		else $error("ram write before write rise");
	AST_WR_STB: assert property (o_write_req && o_strobe_style |->
		!$past(i_data_or_read_strobe)) else $error("strobe write before strobe fall");
	AST_OE_DATA: assert property (o_muxed_addr_data_bus_oe && $past(o_muxed_addr_data_bus_oe)
		|-> o_muxed_addr_data_bus == $past(i_read_data)) else $error("read data wrong");
	// xor covers both styles: strobe low in strobe style, read high in ram style
	AST_OE_END: assert property ((i_data_or_read_strobe ^ o_strobe_style)[*8]
		|-> !o_muxed_addr_data_bus_oe) else $error("bus not released");
	AST_ADDR_CLR: assert property ($rose(i_address_strobe) |-> ##[1:6] !o_addr_valid)
		else $error("address not discarded");
endmodule
bind mbbhp_port mbbhp_port_chk mbbhp_port_chk_inst (.i_core_clk(i_core_clk), .i_rst(i_rst),
	.i_bus_style_select(i_bus_style_select), .i_address_strobe(i_address_strobe),
	.i_data_or_read_strobe(i_data_or_read_strobe), .i_read_write(i_read_write),
	.i_chip_select_n(i_chip_select_n), .i_power_fail_threshold(i_power_fail_threshold),
	.i_read_data(i_read_data), .o_muxed_addr_data_bus(o_muxed_addr_data_bus),
	.o_muxed_addr_data_bus_oe(o_muxed_addr_data_bus_oe), .o_addr_valid(o_addr_valid),
	.o_read_req(o_read_req), .o_write_req(o_write_req), .o_strobe_style(o_strobe_style));

// [mbbhp_host.sv]
// Purpose: host processor model on the muxed byte bus
// Assumes: select and power fail are driven by the bench
// Notes:   released bus shows the inverse, never the last value
`timescale 1ns/10ps
module mbbhp_host (
	input  wire logic       i_core_clk,
	input  wire logic       i_style,
	input  wire logic [7:0] i_bus,
	output logic            o_as = 1'b0,
	output logic            o_ds = 1'b1,
	output logic            o_rw = 1'b1,
	output logic      [7:0] o_bus = 8'h00,
	output logic      [7:0] o_seen = 8'h00
);
	// ==========
	// bus cycles
	task w;
		repeat (10) @(negedge i_core_clk);
	endtask
	task settle;
		o_ds = !i_style;
		w();
		w();
	endtask
	task access(input logic rd, input logic [7:0] a, input logic [7:0] d);
		o_as = 1'b1;
		o_bus = a;
		w();
		o_as = 1'b0;
		w();
		if (i_style) begin
			o_rw = rd;
			// a read releases the bus, which then shows the inverse of the address
			o_bus = rd ? ~a : d;
			w();
			o_ds = 1'b1;
			w();
			o_seen = i_bus;
			o_ds = 1'b0;
		end else if (rd) begin
			o_bus = ~a;
			o_ds = 1'b0;
			w();
			o_seen = i_bus;
			o_ds = 1'b1;
		end else begin
			o_bus = d;
			o_rw = 1'b0;
			w();
			o_rw = 1'b1;
		end
		w();
		o_rw = 1'b1;
		o_bus = ~o_bus;
		// gap so that the next cycle never lands in the same time step
		w();
	endtask
endmodule

// [muxed_byte_bus_host_port_tb_top.sv]
// Purpose: self-checking bench for the muxed byte bus host port
// Assumes: host model drives strobes, bench drives select and power fail
// Notes:   both styles run the same scenario list
`timescale 1ns/10ps
module muxed_byte_bus_host_port_tb_top;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       sty = 1'b0;
	logic       cs_n = 1'b1;
	logic       pf = 1'b0;
	logic [7:0] rdat = 8'h00;
	logic       as_p, ds_p, rw_p, oe, wrq, rrq, av, stl;
	logic [7:0] hbus, dbus, bus, addr, wdat, seen, wa, wd, la;
	int         n_wr, n_rd, n_oe, n_fail, comparisons;
	always #4 clk = ~clk;
	assign bus = oe ? dbus : hbus;
	mbbhp_host mbbhp_host_inst (.i_core_clk(clk), .i_style(sty), .i_bus(bus), .o_as(as_p),
		.o_ds(ds_p), .o_rw(rw_p), .o_bus(hbus), .o_seen(seen));
	mbbhp_port mbbhp_port_inst (.i_core_clk(clk), .i_rst(rst), .i_bus_style_select(sty),
		.i_address_strobe(as_p), .i_data_or_read_strobe(ds_p), .i_read_write(rw_p),
		.i_chip_select_n(cs_n), .i_power_fail_threshold(pf), .i_muxed_addr_data_bus(bus),
		.o_muxed_addr_data_bus(dbus), .o_muxed_addr_data_bus_oe(oe), .i_read_data(rdat),
		.o_addr(addr), .o_addr_valid(av), .o_read_req(rrq), .o_write_data(wdat),
		.o_write_req(wrq), .o_strobe_style(stl));
	always @(posedge clk) begin
		if (wrq === 1'b1) begin
			n_wr++;
			wa = addr;
			wd = wdat;
		end
		if (rrq === 1'b1)
			n_rd++;
		if (oe === 1'b1)
			n_oe++;
		if (av === 1'b1)
			la = addr;
	end
	task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s exp %h got %h", nm, e, s);
		end
	endtask
	task clr;
		n_wr = 0;
		n_rd = 0;
		n_oe = 0;
	endtask
	task t_write(input logic [7:0] a, input logic [7:0] d);
		clr();
		mbbhp_host_inst.access(1'b0, a, d);
		chk("wr_req", 8'h01, 8'(n_wr));
		chk("wr_data", d, wd);
		chk("wr_addr", a, wa);
	endtask
	task t_read(input logic [7:0] a, input logic [7:0] d);
		clr();
		rdat = d;
		mbbhp_host_inst.access(1'b1, a, 8'h00);
		chk("rd_req", 8'h01, 8'(n_rd));
		chk("rd_data", d, seen);
		chk("rd_addr", a, la);
		chk("oe_end", 8'h00, {7'h00, oe});
	endtask
	// power fail must block even with select held low
	task t_block(input logic use_pf, input logic [7:0] a);
		clr();
		cs_n = !use_pf;
		pf = use_pf;
		mbbhp_host_inst.access(1'b0, a, 8'hFF);
		mbbhp_host_inst.access(1'b1, a, 8'h00);
		chk("blk_req", 8'h00, 8'(n_wr + n_rd + n_oe));
		chk("blk_addr", a, la);
		cs_n = 1'b0;
		pf = 1'b0;
		// let the restored levels settle before anyone drives them again
		repeat (10) @(negedge clk);
	endtask
	task summarize;
		$display("fails %0d comparisons %0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		for (int s = 0; s < 2; s++) begin
			cs_n = 1'b1;
			sty = s[0];
			mbbhp_host_inst.settle();
			chk("style", {7'h00, sty}, {7'h00, stl});
			cs_n = 1'b0;
			t_write(8'h3C, 8'hA5);
			t_read(8'h0F, 8'h5A);
			t_block(1'b0, 8'h21);
			t_block(1'b1, 8'h42);
		end
		summarize();
	end
	initial begin
		#100000;
		n_fail++;
		summarize();
	end
endmodule
